// >>> sbr_pkg.sv
// Shared constants, register map and carrier types for the downstream reset block
package sbr_pkg;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam int CTRL_RESET_BIT = 0;
    localparam int ST_RESET_OUT_BIT = 0;
    localparam int ST_UP_RESET_BIT = 1;
    localparam int ST_FAST_BIT = 2;
    localparam int ST_INT_ARB_BIT = 3;
    localparam int ST_SW_RESET_BIT = 4;
    localparam logic CTRL_RESET_INIT = 1'b0;
    localparam int AD_W = 32;
    localparam int CBE_W = 4;
    localparam int CTL_W = 8;
    localparam int FAST_MHZ = 66;
    localparam int SLOW_MHZ = 33;
    localparam logic [31:0] ERR_NONE = 32'h0000_0000;

    typedef struct packed {
        logic [AD_W-1:0] ad;
        logic [CBE_W-1:0] cbe;
        logic par;
        logic [CTL_W-1:0] ctl;
    } sbr_bus_t;

    typedef struct packed {
        logic [AD_W-1:0] ad;
        logic [CBE_W-1:0] cbe;
        logic par;
        logic [CTL_W-1:0] ctl_oe_n;
        logic data_oe_n;
    } sbr_drive_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sbr_apb_req_t;
endpackage : sbr_pkg

// >>> sbr_sync.sv
// Two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sbr_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic init,
    input wire logic d,
    output logic q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sbr_sync_st_t;
    sbr_sync_st_t st;
    sbr_sync_st_t next_st;
    logic init_q;
    assign init_q = init;
    always_comb
    begin
        next_st = st;
        if (ce)
        begin
            next_st.s1 = d;
            next_st.s2 = st.s1;
        end
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            st <= '0;
        else
            st <= next_st;
    end
    assign q = st.s2 ^ init_q;
endmodule : sbr_sync

// >>> sbr_apb.sv
// APB slave holding the control bit and reading back status
`timescale 1ns/1ps
module sbr_apb (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire sbr_pkg::sbr_apb_req_t req,
    input wire logic [4:0] status,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic sw_reset
);
    typedef struct packed {
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic sw_reset;
    } sbr_apb_st_t;
    sbr_apb_st_t st;
    sbr_apb_st_t next_st;
    function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
        hit = (a == b);
    endfunction : hit
    always_comb
    begin
        next_st = st;
        next_st.ready = 1'b0;
        if (ce && req.psel && req.penable && !st.ready)
        begin
            next_st.ready = 1'b1;
            next_st.err = 1'b0;
            next_st.rdata = sbr_pkg::ERR_NONE;
            if (hit(req.paddr, sbr_pkg::ADDR_CTRL))
            begin
                if (req.pwrite)
                    next_st.sw_reset = req.pwdata[sbr_pkg::CTRL_RESET_BIT];
                next_st.rdata[sbr_pkg::CTRL_RESET_BIT] = st.sw_reset;
            end
            else if (hit(req.paddr, sbr_pkg::ADDR_STATUS))
            begin
                if (!req.pwrite)
                    next_st.rdata = {27'h0000000, status};
            end
            else
                next_st.err = 1'b1;
        end
        else if (ce)
            next_st.ready = 1'b0;
        else
            next_st.ready = st.ready;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.sw_reset <= sbr_pkg::CTRL_RESET_INIT;
        end
        else
            st <= next_st;
    end
    assign pready = st.ready;
    assign pslverr = st.err;
    assign prdata = st.rdata;
    assign sw_reset = st.sw_reset;
endmodule : sbr_apb

// >>> sbr_top.sv
// Downstream bus reset, parking, fast-clock report and arbiter strap
// What this block does
// [RULE1] Upstream reset asserts downstream reset
// [RULE2] Software reset bit asserts downstream reset
// [RULE3] Control outputs float during downstream reset
// [RULE4] Drive zero data, byte enables, parity
// [RULE5] Fast capability high permits 66MHz
// [RULE6] Fast capability low limits to 33MHz
// [RULE7] Upstream low pulls downstream capability low
// [RULE8] Strap low enables internal arbiter
// [RULE9] Strap high means board arbiter used
// [RULE10] Release only when both causes clear
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module sbr_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic upstream_reset_n,
    input wire logic upstream_fast_clock_capable,
    input wire logic downstream_fast_clock_capable_in,
    input wire logic arbiter_select_strap_n,
    input wire sbr_pkg::sbr_bus_t core_bus,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic downstream_reset_n,
    output sbr_pkg::sbr_drive_t bus_drive,
    output logic downstream_fast_clock_capable_out,
    output logic downstream_fast_clock_capable_oe_n,
    output logic fast_66_allowed,
    output logic internal_arbiter_enable
);
    typedef struct packed {
        logic rst_n;
        sbr_pkg::sbr_drive_t drv;
        logic fast_oe_n;
        logic fast_ok;
        logic int_arb;
        logic strap_done;
    } sbr_top_st_t;
    sbr_top_st_t st;
    sbr_top_st_t next_st;
    logic up_rst_n_s;
    logic up_fast_s;
    logic dn_fast_s;
    logic strap_n_s;
    logic sw_reset;
    logic [4:0] status;
    sbr_pkg::sbr_apb_req_t req;

    sbr_sync u_sync_rst (.clk(clk), .arst_n(arst_n), .ce(ce), .init(1'b0),
        .d(upstream_reset_n), .q(up_rst_n_s));
    sbr_sync u_sync_upf (.clk(clk), .arst_n(arst_n), .ce(ce), .init(1'b0),
        .d(upstream_fast_clock_capable), .q(up_fast_s));
    sbr_sync u_sync_dnf (.clk(clk), .arst_n(arst_n), .ce(ce), .init(1'b0),
        .d(downstream_fast_clock_capable_in), .q(dn_fast_s));
    sbr_sync u_sync_arb (.clk(clk), .arst_n(arst_n), .ce(ce), .init(1'b0),
        .d(arbiter_select_strap_n), .q(strap_n_s));

    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
    assign status = {sw_reset, st.int_arb, st.fast_ok, !up_rst_n_s, !st.rst_n};

    sbr_apb u_apb (.clk(clk), .arst_n(arst_n), .ce(ce), .req(req), .status(status),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .sw_reset(sw_reset));

    always_comb
    begin
        next_st = st;
        if (ce)
        begin
            next_st.rst_n = up_rst_n_s && !sw_reset; // [RULE1] [RULE2] [RULE10]
            if (!next_st.rst_n)
            begin
                next_st.drv.ctl_oe_n = '1; // [RULE3]
                next_st.drv.ad = '0; // [RULE4]
                next_st.drv.cbe = '0; // [RULE4]
                next_st.drv.par = 1'b0; // [RULE4]
                next_st.drv.data_oe_n = 1'b0; // [RULE4]
            end
            else
            begin
                next_st.drv.ctl_oe_n = ~core_bus.ctl;
                next_st.drv.ad = core_bus.ad;
                next_st.drv.cbe = core_bus.cbe;
                next_st.drv.par = core_bus.par;
                next_st.drv.data_oe_n = 1'b1;
            end
            next_st.fast_oe_n = up_fast_s; // [RULE7]
            next_st.fast_ok = dn_fast_s && up_fast_s; // [RULE5] [RULE6]
            if (!up_rst_n_s)
            begin
                next_st.int_arb = !strap_n_s; // [RULE8] [RULE9]
                next_st.strap_done = 1'b0;
            end
            else if (!st.strap_done)
            begin
                next_st.int_arb = !strap_n_s; // [RULE8]
                next_st.strap_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st <= '0;
            st.drv.ctl_oe_n <= '1;
            st.drv.data_oe_n <= 1'b0;
            st.fast_oe_n <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign downstream_reset_n = st.rst_n;
    assign bus_drive = st.drv;
    assign downstream_fast_clock_capable_out = 1'b0;
    assign downstream_fast_clock_capable_oe_n = st.fast_oe_n;
    assign fast_66_allowed = st.fast_ok;
    assign internal_arbiter_enable = st.int_arb;

    up_reset_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE1]
        ce && !up_rst_n_s |=> !downstream_reset_n)
        else $error("upstream reset not passed on");
    sw_reset_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE2]
        ce && sw_reset |=> !downstream_reset_n)
        else $error("software reset not passed on");
    release_ok_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
        $rose(downstream_reset_n) |-> $past(up_rst_n_s) && !$past(sw_reset))
        else $error("reset released early");
    release_clear_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE10]
        ce && up_rst_n_s && !sw_reset |=> downstream_reset_n)
        else $error("reset not released");
    ctl_float_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE3]
        !downstream_reset_n |-> bus_drive.ctl_oe_n == '1)
        else $error("control driven in reset");
    data_zero_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE4]
        !downstream_reset_n |-> bus_drive.ad == '0 && bus_drive.cbe == '0
        && !bus_drive.par && !bus_drive.data_oe_n)
        else $error("data not parked at zero");
    fast_pull_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE7]
        ce && !up_fast_s |=> !downstream_fast_clock_capable_oe_n)
        else $error("capability not pulled low");
    fast_limit_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE6]
        ce && !dn_fast_s |=> !fast_66_allowed)
        else $error("66MHz allowed when low");
    fast_permit_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE5]
        ce && dn_fast_s && up_fast_s |=> fast_66_allowed)
        else $error("66MHz not reported");
    int_arb_a: assert property (@(posedge clk) disable iff (!arst_n) // [RULE8]
        ce && (!st.strap_done || !up_rst_n_s) |=> internal_arbiter_enable == !$past(strap_n_s))
        else $error("arbiter strap not caught");
    ce_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> $stable(downstream_reset_n) && $stable(internal_arbiter_enable))
        else $error("state moved with clock enable low");

    sw_rst_c: cover property (@(posedge clk) disable iff (!arst_n)
        up_rst_n_s && sw_reset ##2 !downstream_reset_n);
    release_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(downstream_reset_n));
    fast_c: cover property (@(posedge clk) disable iff (!arst_n) $rose(fast_66_allowed));
    ce_c: cover property (@(posedge clk) disable iff (!arst_n) !ce ##1 ce);
endmodule : sbr_top

// >>> sbr_far_model.sv
// Downstream devices sharing the open-drain fast-clock capability wire
`timescale 1ns/1ps
module sbr_far_model (
    input wire logic cap_oe_n,
    input wire logic dev_slow,
    output logic cap_wire
);
    // Pull-up; the bridge or a slow device pulls low
    assign cap_wire = (!cap_oe_n || dev_slow) ? 1'b0 : 1'b1;
endmodule : sbr_far_model

// >>> secondary_bus_reset_and_straps_tb.sv
// Self-checking bench for the downstream reset block
`timescale 1ns/1ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_total++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module secondary_bus_reset_and_straps_tb;
    logic clk, arst_n, ce, up_rst_n, up_cap, dev_slow, strap_n, cap_wire;
    logic psel, penable, pwrite, pready, pslverr, dn_rst_n, cap_out, cap_oe_n, f66, arb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [33:0] e_w;
    logic [33:0] expq[$];
    sbr_pkg::sbr_bus_t core_bus;
    sbr_pkg::sbr_drive_t bus_drive;
    int err_total, num_checks, cyc;
    sbr_top dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .upstream_reset_n(up_rst_n),
        .upstream_fast_clock_capable(up_cap), .downstream_fast_clock_capable_in(cap_wire),
        .arbiter_select_strap_n(strap_n), .core_bus(core_bus), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata), .downstream_reset_n(dn_rst_n),
        .bus_drive(bus_drive), .downstream_fast_clock_capable_out(cap_out),
        .downstream_fast_clock_capable_oe_n(cap_oe_n), .fast_66_allowed(f66),
        .internal_arbiter_enable(arb));
    sbr_far_model far_u (.cap_oe_n(cap_oe_n), .dev_slow(dev_slow), .cap_wire(cap_wire));
    task automatic close_out;
        if (expq.size() != 0)
            err_total++;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out
    // One APB transfer; expectation {is_read, err, data} noted first
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [33:0] e);
        expq.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Looks at the falling edge, returns on a rising edge
    task automatic chk_rst(input logic r);
        core_bus <= sbr_pkg::sbr_bus_t'(45'({$urandom, $urandom}));
        repeat (6) @(posedge clk);
        @(negedge clk);
        `CHK("reset_out", r, dn_rst_n)
        if (!r)
        begin
            `CHK("ctl_oe_n", 8'hFF, bus_drive.ctl_oe_n)
            `CHK("park", 37'h0, {bus_drive.ad, bus_drive.cbe, bus_drive.par})
            `CHK("data_oe_n", 1'b0, bus_drive.data_oe_n)
        end
        else
        begin
            `CHK("ctl_oe_n", ~core_bus.ctl, bus_drive.ctl_oe_n)
            `CHK("ad", core_bus.ad, bus_drive.ad)
            `CHK("cbe_par", {core_bus.cbe, core_bus.par}, {bus_drive.cbe, bus_drive.par})
            `CHK("data_oe_n", 1'b1, bus_drive.data_oe_n)
        end
        @(posedge clk);
    endtask : chk_rst
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // Watcher: each answer against the oldest note
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            err_total++;
            close_out;
        end
        else if (pready === 1'b1 && expq.size() > 0)
        begin
            e_w = expq.pop_front();
            `CHK("pslverr", e_w[32], pslverr)
            if (e_w[33])
                `CHK("prdata", e_w[31:0], prdata)
        end
    end
    initial
    begin
        void'($urandom(48));
        {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {ce, up_rst_n, up_cap, dev_slow, strap_n} = 5'b10100;
        core_bus = '0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        chk_rst(1'b0);
        up_rst_n <= 1'b1;
        chk_rst(1'b1);
        `CHK("int_arb", 1'b1, arb)
        apb(1'b1, sbr_pkg::ADDR_CTRL, 32'h0000_0001, 34'h0);
        chk_rst(1'b0);
        apb(1'b0, sbr_pkg::ADDR_CTRL, 32'h0, {2'b10, 32'h0000_0001});
        apb(1'b0, sbr_pkg::ADDR_STATUS, 32'h0, {2'b10, 32'h0000_001D});
        up_rst_n <= 1'b0;
        apb(1'b1, sbr_pkg::ADDR_CTRL, 32'h0, 34'h0);
        chk_rst(1'b0);
        up_rst_n <= 1'b1;
        chk_rst(1'b1);
        for (int i = 0; i < 4; i++)
        begin
            up_cap <= i[1];
            dev_slow <= i[0];
            repeat (8) @(posedge clk);
            @(negedge clk);
            `CHK("cap_oe_n", i[1], cap_oe_n)
            `CHK("cap_out", 1'b0, cap_out)
            `CHK("fast_66", i[1] & ~i[0], f66)
            @(posedge clk);
        end
        apb(1'b0, 12'h010, 32'h0, {2'b11, 32'h0});
        apb(1'b1, sbr_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 34'h0);
        apb(1'b0, sbr_pkg::ADDR_STATUS, 32'h0, {2'b10, 32'h0000_0008});
        // Clock enable low freezes the reset output
        ce <= 1'b0;
        up_rst_n <= 1'b0;
        strap_n <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        `CHK("frozen", 1'b1, dn_rst_n)
        @(posedge clk);
        ce <= 1'b1;
        chk_rst(1'b0);
        up_rst_n <= 1'b1;
        chk_rst(1'b1);
        `CHK("int_arb", 1'b0, arb)
        // Mid-run reset clears the software bit
        apb(1'b1, sbr_pkg::ADDR_CTRL, 32'h0000_0001, 34'h0);
        arst_n <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        `CHK("arst_out", 1'b0, dn_rst_n)
        `CHK("arst_ready", 1'b0, pready)
        @(posedge clk);
        arst_n <= 1'b1;
        apb(1'b0, sbr_pkg::ADDR_CTRL, 32'h0, {2'b10, 32'h0000_0000});
        chk_rst(1'b1);
        `CHK("int_arb", 1'b0, arb)
        close_out;
    end
endmodule : secondary_bus_reset_and_straps_tb
